// ==== design/branch_pkg.sv ====
// constants and types shared by the branch resolution unit
package branch_pkg;

  // ****************************************************************
  // opcode bytes
  // ****************************************************************
  localparam logic [7:0] OP_INDIRECT_JUMP = 8'h73;  // acc plus pointer
  localparam logic [7:0] OP_BIT_CLEAR     = 8'h30;  // short bit form
  localparam logic [7:0] OP_CARRY_CLEAR   = 8'h50;
  localparam logic [7:0] OP_NOT_EQUAL     = 8'h78;
  localparam logic [7:0] OP_ACC_NONZERO   = 8'h70;
  localparam logic [7:0] OP_ACC_ZERO      = 8'h60;
  localparam logic [7:0] OP_SIGNED_GT     = 8'h18;
  localparam logic [7:0] OP_SIGNED_GE     = 8'h58;
  localparam logic [7:0] OP_SIGNED_LT     = 8'h48;
  localparam logic [7:0] OP_SIGNED_LE     = 8'h08;
  localparam logic [7:0] OP_EXT_BIT       = 8'hA9;  // extended bit group
  localparam logic [4:0] EXT_BIT_CLEAR    = 5'h06;  // sub byte 0011_0yyy

  // ****************************************************************
  // byte counts and state timing
  // ****************************************************************
  localparam logic [3:0] BYTES_ONE   = 4'h1;
  localparam logic [3:0] BYTES_TWO   = 4'h2;
  localparam logic [3:0] BYTES_THREE = 4'h3;
  localparam logic [3:0] BYTES_FOUR  = 4'h4;
  localparam logic [3:0] BYTES_FIVE  = 4'h5;
  localparam logic [3:0] STATES_1    = 4'h1;
  localparam logic [3:0] STATES_2    = 4'h2;
  localparam logic [3:0] STATES_3    = 4'h3;
  localparam logic [3:0] STATES_4    = 4'h4;
  localparam logic [3:0] STATES_5    = 4'h5;
  localparam logic [3:0] STATES_6    = 4'h6;
  localparam logic [3:0] STATES_7    = 4'h7;

  // step from the opcode byte to the next instruction
  localparam logic [15:0] STEP_TWO   = 16'h0002;
  localparam logic [15:0] STEP_THREE = 16'h0003;
  localparam logic [15:0] STEP_FOUR  = 16'h0004;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] REG_CTRL           = 8'h00;
  localparam logic [7:0] REG_STATUS         = 8'h04;
  localparam logic [7:0] REG_LAST_TARGET    = 8'h08;
  localparam logic [7:0] REG_TAKEN_COUNT    = 8'h0C;
  localparam logic [7:0] REG_RESOLVED_COUNT = 8'h10;

  localparam int CTRL_SOURCE_BIT = 0;   // 1: source opcode mode
  localparam int CTRL_ENABLE_BIT = 1;   // 1: accept issues
  localparam logic [1:0] CTRL_RESET = 2'h2;

  localparam int STAT_TAKEN_BIT   = 0;
  localparam int STAT_UNSUP_BIT   = 1;
  localparam int STAT_VALID_BIT   = 2;
  localparam int STAT_OPCODE_LSB  = 8;

  // ****************************************************************
  // branch kinds
  // ****************************************************************
  typedef enum logic [3:0] {
    KIND_NONE,
    KIND_INDIRECT,
    KIND_BIT_CLEAR,
    KIND_CARRY_CLEAR,
    KIND_NOT_EQUAL,
    KIND_ACC_NONZERO,
    KIND_ACC_ZERO,
    KIND_SIGNED_GT,
    KIND_SIGNED_GE,
    KIND_SIGNED_LT,
    KIND_SIGNED_LE
  } br_kind_t;

endpackage

// ==== design/cond_if.sv ====
// interface carrying the branch kind, the status flags and the decision
`timescale 1ns/1ps
`default_nettype none
interface cond_if
  import branch_pkg::*;
();
  br_kind_t   kind;        // branch being resolved
  logic       carry_flag;  // status flags as seen at issue
  logic       overflow_flag;
  logic       negative_flag;
  logic       zero_flag;
  logic       bit_value;   // addressed bit, read only
  logic [7:0] acc;         // accumulator, read only
  logic       take;        // condition holds

  // ****************************************************************
  // modports
  // ****************************************************************
  modport evaluator (
    input  kind, carry_flag, overflow_flag, negative_flag, zero_flag,
    input  bit_value, acc,
    output take
  );
  modport requester (
    output kind, carry_flag, overflow_flag, negative_flag, zero_flag,
    output bit_value, acc,
    input  take
  );
endinterface
`default_nettype wire

// ==== design/cond_eval.sv ====
// condition evaluation for the conditional branches
`timescale 1ns/1ps
`default_nettype none
module cond_eval
  import branch_pkg::*;
(
  // decision port
  cond_if.evaluator c
);

  // ****************************************************************
  // condition table
  // ****************************************************************
  // pure function of kind, flags, bit and accumulator; nothing here ever writes a flag back
  always_comb begin
    case (c.kind)
      KIND_INDIRECT:    c.take = 1'b1;
      // RULE3: taken on zero
      KIND_BIT_CLEAR:   c.take = ~c.bit_value;
      // RULE6: carry clear only
      KIND_CARRY_CLEAR: c.take = ~c.carry_flag;
      // RULE8: zero flag clear
      KIND_NOT_EQUAL:   c.take = ~c.zero_flag;
      // RULE9: any bit set
      KIND_ACC_NONZERO: c.take = |c.acc;
      // RULE10: all bits clear
      KIND_ACC_ZERO:    c.take = ~(|c.acc);
      // RULE11: greater signed test
      KIND_SIGNED_GT:   c.take = ~c.zero_flag &
                                 (c.negative_flag == c.overflow_flag);
      // RULE12: sign matches overflow
      KIND_SIGNED_GE:   c.take = (c.negative_flag == c.overflow_flag);
      // RULE13: sign differs overflow
      KIND_SIGNED_LT:   c.take = (c.negative_flag != c.overflow_flag);
      // RULE14: zero or differ
      KIND_SIGNED_LE:   c.take = c.zero_flag |
                                 (c.negative_flag != c.overflow_flag);
      default:          c.take = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ==== design/target_calc.sv ====
// sequential, relative and indirect target address arithmetic
`timescale 1ns/1ps
`default_nettype none
module target_calc (
  // operands
  input  wire logic [15:0] opcode_pc,     // address of the opcode byte
  input  wire logic [15:0] step,          // opcode byte to next instr
  input  wire logic [7:0]  disp,          // signed displacement
  input  wire logic [7:0]  acc,           // accumulator
  input  wire logic [15:0] data_pointer,  // data pointer
  // results
  output logic      [15:0] seq_pc,        // next sequential address
  output logic      [15:0] rel_pc,        // relative branch target
  output logic      [15:0] ind_pc         // indirect jump target
);

  // ****************************************************************
  // adders
  // ****************************************************************
  // all sums wrap inside 16 bits, as the program counter does
  always_comb begin
    // RULE4: advance then add
    seq_pc = opcode_pc + step;
    // RULE7: sign extended add
    rel_pc = seq_pc + {{8{disp[7]}}, disp};
    // RULE1: zero extended sum
    ind_pc = data_pointer + {8'h00, acc};
  end

endmodule
`default_nettype wire

// ==== design/branch_unit.sv ====
// branch resolution unit: decode, condition, target, timing, registers
//
// How it works
// RULE1: indirect target is pointer plus accumulator
// RULE2: indirect jump changes nothing; 1 byte 5 states
// RULE3: bit clear branches on zero, no write
// RULE4: short bit form steps three then adds
// RULE5: bit clear byte and state timing table
// RULE6: carry clear branch, carry untouched, 1/4
// RULE7: two byte forms step two then add
// RULE8: not equal branches when zero flag clear
// RULE9: nonzero accumulator branch, 2 bytes, 2/5
// RULE10: zero accumulator branch, 2 bytes, 2/5
// RULE11: signed greater: zero clear, sign equals overflow
// RULE12: signed greater equal: sign equals overflow
// RULE13: signed less: sign differs from overflow
// RULE14: signed less equal: zero or differ
// RULE15: escape group bytes and states per mode
// RULE16: fall through to next, flags untouched
// RULE17: taken branch flushes prefetch, refetch target
`timescale 1ns/1ps
`default_nettype none
module branch_unit
  import branch_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // instruction issue from the decode path
  input  wire logic        issue_valid,
  input  wire logic        issue_escaped,
  input  wire logic [7:0]  issue_opcode,
  input  wire logic [7:0]  issue_sub_op,
  input  wire logic [7:0]  issue_disp,
  input  wire logic [15:0] issue_pc,
  // architectural operands
  input  wire logic [7:0]  acc,
  input  wire logic [15:0] data_pointer,
  input  wire logic        carry_flag,
  input  wire logic        overflow_flag,
  input  wire logic        negative_flag,
  input  wire logic        zero_flag,
  input  wire logic        tested_bit,
  // resolution toward the program counter
  output logic             result_valid,
  output logic             result_taken,
  output logic             result_unsupported,
  output logic             load_pc,
  output logic             flush_prefetch,
  output logic      [15:0] next_pc,
  output logic      [3:0]  instr_bytes,
  output logic      [3:0]  instr_states,
  // write enables toward architectural state
  output logic             acc_write,
  output logic             data_pointer_write,
  output logic             flag_write,
  output logic             bit_write
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  cond_if      cif ();               // link to the condition evaluator
  br_kind_t    kind;                 // decoded branch kind
  logic        supported;            // opcode and prefix belong here
  logic [3:0]  bytes_dec;            // length including any prefix
  logic [3:0]  states_nt, states_tk; // states not taken, taken
  logic [15:0] step;                 // opcode byte to next instruction
  logic [15:0] seq_pc, rel_pc;       // fall-through, relative target
  logic [15:0] ind_pc;               // indirect target
  logic        source_mode;          // opcode mode from control
  logic        unit_enable;          // issues accepted
  logic        accept;               // issue taken this cycle
  logic [1:0]  ctrl_q,      ctrl_d;        // control register
  logic        valid_q, valid_d, taken_q, taken_d, unsup_q, unsup_d;
  logic [15:0] pc_q,        pc_d;          // resolved address
  logic [3:0]  bytes_q, bytes_d, states_q, states_d;
  logic        st_taken_q, st_taken_d, st_unsup_q, st_unsup_d;
  logic        st_valid_q,  st_valid_d;    // any result seen
  logic [7:0]  st_op_q,     st_op_d;
  logic [15:0] last_pc_q,   last_pc_d;
  logic [15:0] taken_cnt_q, taken_cnt_d, res_cnt_q, res_cnt_d;
  logic [31:0] rdata_q,     rdata_d;       // read data, one cycle
  assign source_mode = ctrl_q[CTRL_SOURCE_BIT];
  assign unit_enable = ctrl_q[CTRL_ENABLE_BIT];
  assign accept      = issue_valid & unit_enable;

  // ****************************************************************
  // decode
  // ****************************************************************
  // the escape prefix is required in binary mode and forbidden in
  // source mode for the escape group; other opcodes never take it
  always_comb begin
    kind      = KIND_NONE;
    supported = 1'b0;
    bytes_dec = BYTES_ONE;
    states_nt = STATES_1;
    states_tk = STATES_1;
    step      = STEP_TWO;
    case (issue_opcode)
      OP_INDIRECT_JUMP: begin
        // RULE2: one byte five
        kind      = KIND_INDIRECT;
        supported = ~issue_escaped;
        states_nt = STATES_5;
        states_tk = STATES_5;
      end
      OP_BIT_CLEAR: begin
        // RULE5: short form timing
        kind      = KIND_BIT_CLEAR;
        supported = ~issue_escaped;
        bytes_dec = BYTES_THREE;
        states_nt = STATES_2;
        states_tk = STATES_5;
        // RULE4: step of three
        step      = STEP_THREE;
      end
      OP_EXT_BIT: begin
        // RULE5: extended form timing
        kind      = KIND_BIT_CLEAR;
        supported = (issue_sub_op[7:3] == EXT_BIT_CLEAR) &&
                    (issue_escaped != source_mode);
        bytes_dec = source_mode ? BYTES_FOUR : BYTES_FIVE;
        states_nt = source_mode ? STATES_3 : STATES_4;
        states_tk = source_mode ? STATES_6 : STATES_7;
        step      = STEP_FOUR;
      end
      OP_CARRY_CLEAR: begin
        // RULE6: two bytes 1/4
        kind      = KIND_CARRY_CLEAR;
        supported = ~issue_escaped;
        bytes_dec = BYTES_TWO;
        states_tk = STATES_4;
      end
      OP_ACC_NONZERO, OP_ACC_ZERO: begin
        // RULE9: two bytes 2/5
        // RULE10: same timing
        kind      = (issue_opcode == OP_ACC_ZERO) ? KIND_ACC_ZERO
                                                  : KIND_ACC_NONZERO;
        supported = ~issue_escaped;
        bytes_dec = BYTES_TWO;
        states_nt = STATES_2;
        states_tk = STATES_5;
      end
      OP_NOT_EQUAL, OP_SIGNED_GT, OP_SIGNED_GE, OP_SIGNED_LT,
      OP_SIGNED_LE: begin
        case (issue_opcode)
          OP_NOT_EQUAL: kind = KIND_NOT_EQUAL;
          OP_SIGNED_GT: kind = KIND_SIGNED_GT;
          OP_SIGNED_GE: kind = KIND_SIGNED_GE;
          OP_SIGNED_LT: kind = KIND_SIGNED_LT;
          default:      kind = KIND_SIGNED_LE;
        endcase
        // RULE15: mode dependent timing
        supported = (issue_escaped != source_mode);
        bytes_dec = source_mode ? BYTES_TWO : BYTES_THREE;
        states_nt = source_mode ? STATES_1 : STATES_2;
        states_tk = source_mode ? STATES_4 : STATES_5;
      end
      default: kind = KIND_NONE;
    endcase
  end

  // ****************************************************************
  // condition and target
  // ****************************************************************
  assign cif.kind          = kind;
  assign cif.carry_flag    = carry_flag;
  assign cif.overflow_flag = overflow_flag;
  assign cif.negative_flag = negative_flag;
  assign cif.zero_flag     = zero_flag;
  assign cif.bit_value     = tested_bit;
  assign cif.acc           = acc;

  cond_eval u_cond (.c(cif.evaluator));
  // other operands meet nets of the same name
  target_calc u_target (.opcode_pc(issue_pc), .disp(issue_disp), .*);

  // ****************************************************************
  // resolution stage
  // ****************************************************************
  // one registered stage: the answer stands one cycle after issue
  always_comb begin
    valid_d  = accept;
    taken_d  = 1'b0;
    unsup_d  = 1'b0;
    pc_d     = pc_q;
    bytes_d  = bytes_q;
    states_d = states_q;
    if (accept) begin
      unsup_d  = ~supported;
      bytes_d  = bytes_dec;
      if (!supported) begin
        // unknown here: the core keeps its own sequencing
        states_d = states_nt;
        pc_d     = issue_pc;
      end else if (cif.take) begin
        // the indirect kind always takes
        taken_d  = 1'b1;
        states_d = states_tk;
        // RULE1: indirect target load
        pc_d     = (kind == KIND_INDIRECT) ? ind_pc : rel_pc;
      end else begin
        // RULE16: next sequential instruction
        states_d = states_nt;
        pc_d     = seq_pc;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      valid_q  <= 1'b0;
      taken_q  <= 1'b0;
      unsup_q  <= 1'b0;
      pc_q     <= 16'h0000;
      bytes_q  <= 4'h0;
      states_q <= 4'h0;
    end else begin
      valid_q  <= valid_d;
      taken_q  <= taken_d;
      unsup_q  <= unsup_d;
      pc_q     <= pc_d;
      bytes_q  <= bytes_d;
      states_q <= states_d;
    end
  end

  assign result_valid       = valid_q;
  assign result_taken       = valid_q & taken_q;
  assign result_unsupported = valid_q & unsup_q;
  assign load_pc            = valid_q & ~unsup_q;
  // RULE17: discard prefetched bytes
  assign flush_prefetch     = valid_q & taken_q;
  assign next_pc            = pc_q;
  assign instr_bytes        = bytes_q;
  assign instr_states       = states_q;
  // RULE2: no state written
  // RULE3: tested bit kept
  // RULE16: flags never written
  assign acc_write          = 1'b0;
  assign data_pointer_write         = 1'b0;
  assign flag_write         = 1'b0;
  assign bit_write          = 1'b0;

  // ****************************************************************
  // status and counters
  // ****************************************************************
  // a count write clears; an event in the same cycle still counts
  always_comb begin
    st_taken_d  = st_taken_q;
    st_unsup_d  = st_unsup_q;
    st_valid_d  = st_valid_q;
    st_op_d     = st_op_q;
    last_pc_d   = last_pc_q;
    taken_cnt_d = taken_cnt_q;
    res_cnt_d   = res_cnt_q;
    if (reg_write && reg_addr == REG_TAKEN_COUNT)
      taken_cnt_d = 16'h0000;
    if (reg_write && reg_addr == REG_RESOLVED_COUNT)
      res_cnt_d = 16'h0000;
    if (accept) begin
      st_valid_d = 1'b1;
      st_taken_d = taken_d;
      st_unsup_d = unsup_d;
      st_op_d    = issue_opcode;
      last_pc_d  = pc_d;
      res_cnt_d  = res_cnt_d + 16'h0001;
      if (taken_d)
        taken_cnt_d = taken_cnt_d + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_taken_q  <= 1'b0;
      st_unsup_q  <= 1'b0;
      st_valid_q  <= 1'b0;
      st_op_q     <= 8'h00;
      last_pc_q   <= 16'h0000;
      taken_cnt_q <= 16'h0000;
      res_cnt_q   <= 16'h0000;
    end else begin
      st_taken_q  <= st_taken_d;
      st_unsup_q  <= st_unsup_d;
      st_valid_q  <= st_valid_d;
      st_op_q     <= st_op_d;
      last_pc_q   <= last_pc_d;
      taken_cnt_q <= taken_cnt_d;
      res_cnt_q   <= res_cnt_d;
    end
  end

  // ****************************************************************
  // register port
  // ****************************************************************
  // read data stand only in the cycle after the strobe, else zero
  always_comb begin
    ctrl_d  = ctrl_q;
    rdata_d = 32'h00000000;
    if (reg_write && reg_addr == REG_CTRL)
      ctrl_d = reg_wdata[1:0];
    if (reg_read) begin
      case (reg_addr)
        REG_CTRL:           rdata_d = {30'h00000000, ctrl_q};
        REG_STATUS: begin
          rdata_d[STAT_TAKEN_BIT] = st_taken_q;
          rdata_d[STAT_UNSUP_BIT] = st_unsup_q;
          rdata_d[STAT_VALID_BIT] = st_valid_q;
          rdata_d[STAT_OPCODE_LSB +: 8] = st_op_q;
        end
        REG_LAST_TARGET:    rdata_d = {16'h0000, last_pc_q};
        REG_TAKEN_COUNT:    rdata_d = {16'h0000, taken_cnt_q};
        REG_RESOLVED_COUNT: rdata_d = {16'h0000, res_cnt_q};
        default:            rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q  <= CTRL_RESET;
      rdata_q <= 32'h00000000;
    end else begin
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule
`default_nettype wire

// ==== design/_unused_guard.sv ====
// empty compilation unit, kept for file order

// ==== verif/branch_unit_chk.sv ====
// concurrent checks on the ports of the branch resolution unit
`timescale 1ns/1ps
`default_nettype none
module branch_unit_chk
  import branch_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // issue and operands
  input wire logic        issue_valid,
  input wire logic        issue_escaped,
  input wire logic [7:0]  issue_opcode,
  input wire logic [7:0]  issue_disp,
  input wire logic [15:0] issue_pc,
  input wire logic [7:0]  acc,
  input wire logic [15:0] data_pointer,
  input wire logic        carry_flag,
  input wire logic        tested_bit,
  // resolution
  input wire logic        result_valid,
  input wire logic        result_taken,
  input wire logic        result_unsupported,
  input wire logic        load_pc,
  input wire logic        flush_prefetch,
  input wire logic [15:0] next_pc,
  input wire logic [3:0]  instr_bytes,
  input wire logic [3:0]  instr_states,
  // write enables
  input wire logic        acc_write,
  input wire logic        data_pointer_write,
  input wire logic        flag_write,
  input wire logic        bit_write
);
  // ********************************************************
  // helpers and properties
  // ********************************************************
  logic [15:0] disp_x;  // sign-extended displacement
  assign disp_x = {{8{issue_disp[7]}}, issue_disp};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  no_state_write_a: assert property (
    !(acc_write | data_pointer_write | flag_write | bit_write))
    else $error("architectural write enable raised");
  flush_taken_a: assert property (
    flush_prefetch == (result_valid && result_taken))
    else $error("flush does not follow a taken result");
  load_supported_a: assert property (
    load_pc == (result_valid && !result_unsupported))
    else $error("pc load does not follow a supported result");
  indirect_sum_a: assert property (
    issue_valid && !issue_escaped && issue_opcode == OP_INDIRECT_JUMP
    ##1 result_valid |-> result_taken && instr_bytes == BYTES_ONE
    && instr_states == STATES_5
    && next_pc == $past(data_pointer) + {8'h00, $past(acc)})
    else $error("indirect jump result wrong");
  carry_clear_a: assert property (
    issue_valid && !issue_escaped && issue_opcode == OP_CARRY_CLEAR
    ##1 result_valid |-> result_taken == !$past(carry_flag)
    && instr_states == (result_taken ? STATES_4 : STATES_1)
    && next_pc == $past(issue_pc) + STEP_TWO
       + (result_taken ? $past(disp_x) : 16'h0000))
    else $error("carry clear branch result wrong");
  bit_clear_a: assert property (
    issue_valid && !issue_escaped && issue_opcode == OP_BIT_CLEAR
    ##1 result_valid |-> result_taken == !$past(tested_bit)
    && instr_bytes == BYTES_THREE
    && instr_states == (result_taken ? STATES_5 : STATES_2)
    && next_pc == $past(issue_pc) + STEP_THREE
       + (result_taken ? $past(disp_x) : 16'h0000))
    else $error("bit clear branch result wrong");
  acc_zero_a: assert property (
    issue_valid && !issue_escaped && issue_opcode == OP_ACC_ZERO
    ##1 result_valid |-> result_taken == ($past(acc) == 8'h00)
    && instr_bytes == BYTES_TWO)
    else $error("zero accumulator branch result wrong");
  acc_nonzero_a: assert property (
    issue_valid && !issue_escaped && issue_opcode == OP_ACC_NONZERO
    ##1 result_valid |-> result_taken == ($past(acc) != 8'h00)
    && instr_states == (result_taken ? STATES_5 : STATES_2))
    else $error("nonzero accumulator branch result wrong");
endmodule

bind branch_unit branch_unit_chk chk_u (.*);
`default_nettype wire

// ==== verif/fetch_model.sv ====
// model of the core fetch path that follows resolved targets
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // resolution from the unit
  input  wire logic        load_pc,
  input  wire logic [15:0] next_pc,
  // fetch address in use
  output logic      [15:0] fetch_pc
);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fetch_pc <= 16'h0000;
    end else if (load_pc) begin
      fetch_pc <= next_pc;
    end
  end
endmodule
`default_nettype wire

// ==== verif/conditional_jump_branch_unit_test.sv ====
// self-checking bench for the branch resolution unit
`timescale 1ns/1ps
`default_nettype none
module conditional_jump_branch_unit_test
  import branch_pkg::*;
;
  logic        ref_clk, rst, reg_write, reg_read, issue_valid;
  logic        issue_escaped, carry_flag, overflow_flag, negative_flag;
  logic        zero_flag, tested_bit, result_valid, result_taken;
  logic        result_unsupported, load_pc, flush_prefetch, en;
  logic [7:0]  reg_addr, issue_opcode, issue_sub_op, issue_disp, acc;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] issue_pc, data_pointer, next_pc, fetch_pc, last_pc;
  logic [3:0]  instr_bytes, instr_states;
  int          mismatches, n_compared, seed, nt;
  int          ops[11] = '{'h73, 'h30, 'hA9, 'h50, 'h70, 'h60, 'h78,
                           'h18, 'h58, 'h48, 'h08};

  branch_unit dut_u (.*, .acc_write(), .data_pointer_write(), .flag_write(),
                     .bit_write());
  fetch_model pm_u (.*);

  // ********************************************************
  // shared tasks
  // ********************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // one issue with random operands, checked against the model
  task automatic iss(input int op, input bit src, input bit flip);
    logic [31:0] r1, r2;
    logic [15:0] tp;
    bit          g, t, sup, esc;
    int          byt, st;
    r1 = $random(seed);
    r2 = $random(seed);
    g = op inside {'h78, 'h18, 'h58, 'h48, 'h08};
    esc = ((g || op == 'hA9) && !src) ^ flip;
    @(posedge ref_clk);
    issue_valid <= 1'b1;
    issue_escaped <= esc;
    issue_opcode <= op[7:0];
    issue_sub_op <= {5'b00110, r1[31:29]};
    issue_disp <= r1[23:16];
    acc <= r1[7:0] & {8{r1[8]}};
    {carry_flag, overflow_flag, negative_flag} <= r1[26:24];
    {zero_flag, tested_bit} <= r1[28:27];
    data_pointer <= r2[15:0];
    issue_pc <= r2[31:16];
    #1 chk(fetch_pc, last_pc);
    // model of the condition, sizes and timing
    case (op)
      'h73: t = 1;
      'h30, 'hA9: t = !tested_bit;
      'h50: t = !carry_flag;
      'h70: t = acc != 8'h00;
      'h60: t = acc == 8'h00;
      'h78: t = !zero_flag;
      'h18: t = !zero_flag && negative_flag == overflow_flag;
      'h58: t = negative_flag == overflow_flag;
      'h48: t = negative_flag != overflow_flag;
      default: t = zero_flag || negative_flag != overflow_flag;
    endcase
    sup = (g || op == 'hA9) ? esc == !src : !esc;
    t = t && sup && en;
    byt = op == 'h73 ? 1 : op == 'h30 ? 3 : op == 'hA9 ? 5 - src
        : g ? 3 - src : 2;
    st = (op == 'hA9 ? 4 - src : g ? 2 - src : op == 'h50 ? 1 : 2)
       + 3 * t;
    tp = issue_pc + (op == 'h30 ? 3 : op == 'hA9 ? 4 : 2)
       + (t ? {{8{issue_disp[7]}}, issue_disp} : 16'h0000);
    if (op == 'h73) tp = data_pointer + {8'h00, acc};
    @(posedge ref_clk);
    issue_valid <= 1'b0;
    #1;
    if (!en) begin
      chk(result_valid, 1'b0);
    end else begin
      chk({result_valid, result_taken, result_unsupported, load_pc,
           flush_prefetch}, {1'b1, t, !sup, sup, t});
      chk(next_pc, sup ? tp : issue_pc);
      if (sup) chk({instr_bytes, instr_states}, {byt[3:0], st[3:0]});
      if (sup) last_pc = tp;
      nt += t;
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ********************************************************
  // clock and main sequence
  // ********************************************************
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    {reg_addr, reg_wdata, reg_write, reg_read, issue_valid} = '0;
    {issue_escaped, issue_opcode, issue_sub_op, issue_disp} = '0;
    {issue_pc, acc, data_pointer, carry_flag, overflow_flag} = '0;
    {negative_flag, zero_flag, tested_bit} = '0;
    {mismatches, n_compared, nt, last_pc} = '0;
    seed = 51174;
    en = 1'b1;
    rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rd(REG_CTRL, {30'h0, CTRL_RESET});
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0);
    // every opcode in both modes; first round has the prefix wrong
    for (int s = 0; s < 2; s++) begin
      wr(REG_CTRL, 32'(2 + s));
      for (int r = 0; r < 12; r++) begin
        foreach (ops[i]) iss(ops[i], s[0], r == 0);
      end
    end
    // disabled unit ignores issues
    en = 1'b0;
    wr(REG_CTRL, 32'h0);
    iss('h50, 1'b0, 1'b0);
    rd(REG_TAKEN_COUNT, 32'(nt));
    rd(REG_RESOLVED_COUNT, 32'd264);
    rd(REG_LAST_TARGET, {16'h0, last_pc});
    wr(REG_TAKEN_COUNT, 32'h0);
    rd(REG_TAKEN_COUNT, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
